// File: rtl/mct_pkg.sv
package mct_pkg;

    // Channel counts and data width.
    localparam int NUM_MATCH = 4;
    localparam int NUM_CAPT = 4;
    localparam int NUM_PWM = 3;
    localparam int DW = 32;
    localparam int AW = 8;

    // Register byte addresses.
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_COUNT = 8'h04;
    localparam logic [7:0] ADDR_PRESC = 8'h08;
    localparam logic [7:0] ADDR_PCNT = 8'h0c;
    localparam logic [7:0] ADDR_MCTL = 8'h10;
    localparam logic [7:0] ADDR_MOUT = 8'h14;
    localparam logic [7:0] ADDR_CCTL = 8'h18;
    localparam logic [7:0] ADDR_PWM = 8'h1c;
    localparam logic [7:0] ADDR_DMA = 8'h20;
    localparam logic [7:0] ADDR_STAT = 8'h24;
    localparam logic [7:0] ADDR_MASK = 8'h28;
    localparam logic [3:0] PAGE_MATCH = 4'h3;
    localparam logic [3:0] PAGE_CAPT = 4'h4;

    // Control register fields.
    localparam int CTRL_EN = 0;
    localparam int CTRL_EXT = 1;
    localparam int CTRL_CLR_EN = 2;
    localparam int CTRL_CLR_SEL = 4;

    // Per-channel fields, three bits per channel.
    localparam int FLD_STRIDE = 3;
    localparam int MC_INT = 0;
    localparam int MC_RST = 1;
    localparam int MC_STOP = 2;
    localparam int CC_RISE = 0;
    localparam int CC_FALL = 1;
    localparam int CC_INT = 2;

    // Match output register: actions in [7:0], pin levels in [11:8].
    localparam int MOUT_LVL = 8;
    // Status and mask layout.
    localparam int ST_CAPT = 4;

    // Reset values.
    localparam logic [31:0] RST_WORD = 32'h0000_0000;

    // Action taken on a match output pin.
    typedef enum logic [1:0] {MCT_ACT_NONE, MCT_ACT_LOW, MCT_ACT_HIGH, MCT_ACT_TOGGLE} mct_act_t;

    // Register port request.
    typedef struct packed {
        logic [AW-1:0] addr;
        logic [DW-1:0] wdata;
        logic wr;
        logic rd;
    } mct_bus_req_t;

    // Complete state of the timer.
    typedef struct packed {
        logic en;
        logic ext;
        logic clr_en;
        logic [1:0] clr_sel;
        logic [DW-1:0] tc;
        logic [DW-1:0] pr;
        logic [DW-1:0] pc;
        logic [11:0] mctl;
        logic [11:0] cctl;
        logic [NUM_MATCH-1:0][1:0] act;
        logic [NUM_MATCH-1:0] mout;
        logic [NUM_PWM-1:0] pwm;
        logic [1:0] dma_en;
        logic [1:0] dma;
        logic [7:0] stat;
        logic [7:0] mask;
        logic [NUM_MATCH-1:0][DW-1:0] msh;
        logic [NUM_MATCH-1:0][DW-1:0] mval;
        logic [NUM_CAPT-1:0][DW-1:0] cap;
        logic [2:0] ext_sy;
        logic [2:0][NUM_CAPT-1:0] cap_sy;
        logic [DW-1:0] rdata;
    } mct_state_t;

endpackage

// File: rtl/mct_timer.sv
`timescale 1ns/1ps
`default_nettype none

module mct_timer #(
    parameter int NUM_DMA = 2
) (
    input wire logic clk_in, // System clock, 10 MHz.
    input wire logic rst_n_in, // Asynchronous reset, active low.
    input wire mct_pkg::mct_bus_req_t bus_in, // Register port request.
    output logic [31:0] rdata_out, // Read data, cycle after the read strobe.
    input wire logic ext_clk_in, // External count clock pin.
    input wire logic [3:0] cap_in, // Capture input pins.
    output logic [3:0] mout_out, // Match output pins.
    output logic [1:0] dma_req_out, // One-cycle DMA request pulses.
    output logic irq_out // Level interrupt.
);

    // Only two DMA request lines exist, so wider settings are refused at elaboration.
    if (NUM_DMA < 0 || NUM_DMA > 2) begin : g_bad_dma
        $error("NUM_DMA must be 0 to 2");
    end

    localparam logic [1:0] DMA_AVAIL = 2'((1 << NUM_DMA) - 1);

    mct_pkg::mct_state_t q, d;
    logic ext_rise;
    logic clk_ev;
    logic tick;
    logic [3:0] cap_rise;
    logic [3:0] cap_fall;
    logic [3:0] cap_ev;
    logic [3:0] match_ev;
    logic rst_ev;
    logic stop_ev;
    logic cap_clr;
    logic wr_count;
    logic wr_ctrl;
    logic [3:0] sets_match;
    logic [3:0] sets_capt;
    logic [7:0] clr_stat;
    logic [31:0] rmux;
    logic [3:0] pwm_on;

    // Pick field number pos out of each three-bit channel group.
    function automatic logic [3:0] chan_bits(input logic [11:0] v, input int pos);
        logic [3:0] r;
        r = 4'h0;
        for (int i = 0; i < 4; i++) begin
            r[i] = v[i * mct_pkg::FLD_STRIDE + pos];
        end
        return r;
    endfunction

    // Read multiplexer; unmapped addresses read as zero.
    always_comb begin
        rmux = mct_pkg::RST_WORD;
        unique case (bus_in.addr)
            mct_pkg::ADDR_CTRL: rmux = 32'({q.clr_sel, 1'b0, q.clr_en, q.ext, q.en});
            mct_pkg::ADDR_COUNT: rmux = q.tc;
            mct_pkg::ADDR_PRESC: rmux = q.pr;
            mct_pkg::ADDR_PCNT: rmux = q.pc;
            mct_pkg::ADDR_MCTL: rmux = 32'(q.mctl);
            mct_pkg::ADDR_MOUT: rmux = 32'({q.mout, q.act});
            mct_pkg::ADDR_CCTL: rmux = 32'(q.cctl);
            mct_pkg::ADDR_PWM: rmux = 32'(q.pwm);
            mct_pkg::ADDR_DMA: rmux = 32'(q.dma_en);
            mct_pkg::ADDR_STAT: rmux = 32'(q.stat);
            mct_pkg::ADDR_MASK: rmux = 32'(q.mask);
            default: begin
                if (bus_in.addr[7:4] == mct_pkg::PAGE_MATCH) begin
                    rmux = q.msh[bus_in.addr[3:2]];
                end else if (bus_in.addr[7:4] == mct_pkg::PAGE_CAPT) begin
                    rmux = q.cap[bus_in.addr[3:2]];
                end
            end
        endcase
    end

    // Event decode from the present state.
    always_comb begin
        ext_rise = q.ext_sy[1] & ~q.ext_sy[2];
        // Padded to four channels so the last match pin never indexes past the PWM enables.
        pwm_on = {1'b0, q.pwm};
        // Edges are taken from the second and third stages only, so a slow edge is seen once.
        cap_rise = q.cap_sy[1] & ~q.cap_sy[2];
        cap_fall = ~q.cap_sy[1] & q.cap_sy[2];
        clk_ev = q.ext ? ext_rise : 1'b1;
        tick = q.en && clk_ev && (q.pc == q.pr);
        for (int i = 0; i < 4; i++) begin
            match_ev[i] = tick && (q.tc == q.mval[i]);
        end
        rst_ev = |(match_ev & chan_bits(q.mctl, mct_pkg::MC_RST));
        stop_ev = |(match_ev & chan_bits(q.mctl, mct_pkg::MC_STOP));
        cap_ev = (cap_rise & chan_bits(q.cctl, mct_pkg::CC_RISE)) | (cap_fall & chan_bits(q.cctl, mct_pkg::CC_FALL));
        cap_clr = q.clr_en && cap_ev[q.clr_sel];
        sets_match = match_ev & chan_bits(q.mctl, mct_pkg::MC_INT);
        sets_capt = cap_ev & chan_bits(q.cctl, mct_pkg::CC_INT);
        wr_count = bus_in.wr && (bus_in.addr == mct_pkg::ADDR_COUNT);
        wr_ctrl = bus_in.wr && (bus_in.addr == mct_pkg::ADDR_CTRL);
        clr_stat = (bus_in.wr && bus_in.addr == mct_pkg::ADDR_STAT) ? bus_in.wdata[7:0] : 8'h00;
    end

    // Next-state logic; software writes come last so they win over counting.
    always_comb begin
        d = q;
        d.ext_sy = {q.ext_sy[1:0], ext_clk_in};
        d.cap_sy = {q.cap_sy[1:0], cap_in};
        // Prescaler counts input clocks and wraps at its limit.
        if (q.en && clk_ev) begin
            if (tick) begin
                d.pc = mct_pkg::RST_WORD;
                if (rst_ev) begin
                    d.tc = mct_pkg::RST_WORD;
                end else if (!stop_ev) begin
                    d.tc = q.tc + 32'h0000_0001;
                end
            end else begin
                d.pc = q.pc + 32'h0000_0001;
            end
        end
        if (stop_ev) begin
            d.en = 1'b0;
        end
        // Active match values follow the shadows only at a period boundary or while idle.
        if (rst_ev || !q.en) begin
            d.mval = q.msh;
        end
        // Match pins: PWM channels fall at the period start and rise on their own match.
        for (int i = 0; i < 4; i++) begin
            if (pwm_on[i] && rst_ev) begin
                d.mout[i] = 1'b0;
            end
            if (match_ev[i]) begin
                if (pwm_on[i]) begin
                    d.mout[i] = 1'b1;
                end else begin
                    unique case (mct_pkg::mct_act_t'(q.act[i]))
                        mct_pkg::MCT_ACT_NONE: d.mout[i] = q.mout[i];
                        mct_pkg::MCT_ACT_LOW: d.mout[i] = 1'b0;
                        mct_pkg::MCT_ACT_HIGH: d.mout[i] = 1'b1;
                        mct_pkg::MCT_ACT_TOGGLE: d.mout[i] = ~q.mout[i];
                    endcase
                end
            end
        end
        d.dma = match_ev[1:0] & q.dma_en & DMA_AVAIL;
        // Captures snapshot the count as it stands before this edge.
        for (int c = 0; c < 4; c++) begin
            if (cap_ev[c]) begin
                d.cap[c] = q.tc;
            end
        end
        if (cap_clr) begin
            d.tc = mct_pkg::RST_WORD;
            d.pc = mct_pkg::RST_WORD;
        end
        // Sticky status: a new event wins over a clear in the same cycle.
        d.stat = (q.stat & ~clr_stat) | {sets_capt, sets_match};
        // Register writes.
        if (bus_in.wr) begin
            unique case (bus_in.addr)
                mct_pkg::ADDR_CTRL: begin
                    d.en = bus_in.wdata[mct_pkg::CTRL_EN];
                    d.ext = bus_in.wdata[mct_pkg::CTRL_EXT];
                    d.clr_en = bus_in.wdata[mct_pkg::CTRL_CLR_EN];
                    d.clr_sel = bus_in.wdata[mct_pkg::CTRL_CLR_SEL +: 2];
                end
                mct_pkg::ADDR_COUNT: d.tc = bus_in.wdata;
                mct_pkg::ADDR_PRESC: d.pr = bus_in.wdata;
                mct_pkg::ADDR_MCTL: d.mctl = bus_in.wdata[11:0];
                mct_pkg::ADDR_MOUT: begin
                    d.act = bus_in.wdata[7:0];
                    d.mout = bus_in.wdata[mct_pkg::MOUT_LVL +: 4];
                end
                mct_pkg::ADDR_CCTL: d.cctl = bus_in.wdata[11:0];
                mct_pkg::ADDR_PWM: d.pwm = bus_in.wdata[2:0];
                mct_pkg::ADDR_DMA: d.dma_en = bus_in.wdata[1:0];
                mct_pkg::ADDR_MASK: d.mask = bus_in.wdata[7:0];
                default: begin
                    if (bus_in.addr[7:4] == mct_pkg::PAGE_MATCH) begin
                        d.msh[bus_in.addr[3:2]] = bus_in.wdata;
                    end
                end
            endcase
        end
        // Read data stands for exactly one cycle.
        d.rdata = bus_in.rd ? rmux : mct_pkg::RST_WORD;
    end

    // The whole state is one register.
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // Outputs come straight from flops; the interrupt is a gate on the eight status and eight mask flops.
    assign rdata_out = q.rdata;
    assign mout_out = q.mout;
    assign dma_req_out = q.dma;
    assign irq_out = |(q.stat & q.mask);

    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rst_n_in);

    sequence s_plain_tick;
        tick && !rst_ev && !stop_ev && !cap_clr && !wr_count;
    endsequence

    sequence s_match_write;
        bus_in.wr && bus_in.addr == {mct_pkg::PAGE_MATCH, 4'h0} && q.en && !rst_ev;
    endsequence

    sequence s_dma_req;
        match_ev[0] && q.dma_en[0] && DMA_AVAIL[0];
    endsequence

    a_count_step: assert property (s_plain_tick |=> q.tc == $past(q.tc) + 32'h0000_0001)
        else $error("counter did not advance on tick");
    a_presc_wrap: assert property (tick && !cap_clr |=> q.pc == mct_pkg::RST_WORD)
        else $error("prescaler did not wrap");
    a_stop_halts: assert property (stop_ev && !wr_ctrl |=> !q.en ##1 $stable(q.tc))
        else $error("stop on match did not halt");
    a_reset_zero: assert property (rst_ev && !cap_clr && !wr_count |=> q.tc == mct_pkg::RST_WORD)
        else $error("reset on match did not zero counter");
    a_capture_load: assert property (cap_ev[0] |=> q.cap[0] == $past(q.tc))
        else $error("capture did not load count");
    a_capture_sync: assert property (cap_rise[0] |-> $past(cap_in[0], 2) && !$past(cap_in[0], 3))
        else $error("capture edge not two stages late");
    a_toggle_pin: assert property (match_ev[0] && q.act[0] == 2'h3 && !q.pwm[0] && !(bus_in.wr
        && bus_in.addr == mct_pkg::ADDR_MOUT) |=> mout_out[0] != $past(mout_out[0]))
        else $error("toggle on match failed");
    a_shadow_hold: assert property (s_match_write |=> $stable(q.mval[0]))
        else $error("active match changed mid period");
    a_dma_pulse: assert property (s_dma_req |=> dma_req_out[0])
        else $error("DMA request missing");
    a_clear_capture: assert property (cap_clr && !wr_count |=> q.tc == mct_pkg::RST_WORD
        && q.pc == mct_pkg::RST_WORD)
        else $error("capture clear failed");
    a_capt_irq: assert property (sets_capt[0] && q.mask[mct_pkg::ST_CAPT] |=> irq_out)
        else $error("capture interrupt missing");
    a_pwm_edges: assert property (pwm_on[0] && (rst_ev || match_ev[0]) && !(bus_in.wr
        && bus_in.addr == mct_pkg::ADDR_MOUT) |=> mout_out[0] == $past(match_ev[0]))
        else $error("PWM pin edge wrong");

endmodule

`default_nettype wire

// File: dv/mct_pin_model.sv
`timescale 1ns/1ps
`default_nettype none

module mct_pin_model (
    input wire logic clk_in, // Bench clock.
    input wire logic rst_n_in, // Reset, active low.
    input wire logic go_in, // Loads a burst length.
    input wire logic [7:0] n_in, // Rising edges to make.
    input wire logic [3:0] lvl_in, // Requested capture levels.
    output logic ext_clk_out, // External count clock.
    output logic [3:0] cap_out // Capture pins.
);
    logic [7:0] left_q;
    logic [1:0] div_q;

    // Pins follow the requested levels; the bench changes them just after an edge.
    assign cap_out = lvl_in;

    // Burst clock with a three-cycle half period, so no edge is lost; it stands low between bursts.
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            left_q <= 8'h00;
            div_q <= 2'h0;
            ext_clk_out <= 1'b0;
        end else if (go_in) begin
            left_q <= n_in;
            div_q <= 2'h0;
        end else if (left_q != 8'h00) begin
            div_q <= (div_q == 2'h2) ? 2'h0 : div_q + 2'h1;
            if (div_q == 2'h2) begin
                ext_clk_out <= ~ext_clk_out;
                if (ext_clk_out) begin
                    left_q <= left_q - 8'h01;
                end
            end
        end
    end
endmodule
`default_nettype wire

// File: dv/tb.sv
`timescale 1ns/1ps
`default_nettype none

module tb;
    logic clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    mct_pkg::mct_bus_req_t bus = '0;
    logic [31:0] rdata;
    logic [31:0] d;
    logic [3:0] cap;
    logic [3:0] mout;
    logic [3:0] lvl = 4'h0;
    logic [1:0] dma;
    logic [7:0] n = 8'h00;
    logic ext_clk;
    logic irq;
    logic go = 1'b0;
    int err_count = 0;
    int num_checks = 0;
    int dma_cnt = 0;
    int dma1_cnt = 0;
    int hi = 0;
    int k, p, m, w;

    // Free-running system clock.
    always #50 clk_in = ~clk_in;

    // Each DMA request lasts one cycle, so sampling at the edge counts it once.
    always @(posedge clk_in) begin
        if (dma[0] === 1'b1) dma_cnt++;
        if (dma[1] === 1'b1) dma1_cnt++;
    end

    mct_timer u_mct_timer (.clk_in(clk_in), .rst_n_in(rst_n_in), .bus_in(bus), .rdata_out(rdata),
        .ext_clk_in(ext_clk), .cap_in(cap), .mout_out(mout), .dma_req_out(dma), .irq_out(irq));
    mct_pin_model u_mct_pin_model (.clk_in(clk_in), .rst_n_in(rst_n_in), .go_in(go), .n_in(n),
        .lvl_in(lvl), .ext_clk_out(ext_clk), .cap_out(cap));

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk_in);
        bus.addr <= a;
        bus.wdata <= v;
        bus.wr <= 1'b1;
        @(posedge clk_in);
        bus.wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe, so they are taken just after that edge.
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge clk_in);
        bus.addr <= a;
        bus.rd <= 1'b1;
        @(posedge clk_in);
        bus.rd <= 1'b0;
        #1;
        v = rdata;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] v;
        rd(a, v);
        chk(v, exp);
    endtask

    // A short reset clears the prescale count, which software cannot write.
    task automatic rst_pulse;
        @(posedge clk_in);
        rst_n_in <= 1'b0;
        @(posedge clk_in);
        rst_n_in <= 1'b1;
    endtask

    task automatic complete_run;
        $display("checks=%0d mismatches=%0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    // The whole sequence needs under a thousand cycles; this bound only catches a hang.
    initial begin
        #3000000;
        err_count++;
        complete_run();
    end

    // Main sequence.
    initial begin
        void'($urandom(32'h38ff));
        repeat (20) @(posedge clk_in);
        rst_n_in <= 1'b1;
        for (k = 0; k < 20; k++) rchk(8'(k * 4), 32'h0);
        chk({27'h0, irq, mout}, 32'h0);
        $display("test reset done");
        for (int i = 0; i < 4; i++) begin
            rst_pulse();
            p = $urandom_range(3, 0);
            k = $urandom_range(30, 5);
            wr(mct_pkg::ADDR_PRESC, 32'(p));
            wr(mct_pkg::ADDR_CTRL, 32'h1);
            repeat (k) @(posedge clk_in);
            wr(mct_pkg::ADDR_CTRL, 32'h0);
            rchk(mct_pkg::ADDR_COUNT, 32'((k + 2) / (p + 1)));
            rchk(mct_pkg::ADDR_PCNT, 32'((k + 2) % (p + 1)));
        end
        $display("test prescale done");
        for (int a = 1; a < 4; a++) begin
            rst_pulse();
            m = $urandom_range(20, 3);
            wr({mct_pkg::PAGE_MATCH, 4'h0}, 32'(m));
            wr(mct_pkg::ADDR_MCTL, 32'h4);
            wr(mct_pkg::ADDR_DMA, 32'h1);
            wr(mct_pkg::ADDR_MOUT, 32'(a) | ((a == 2) ? 32'h0 : 32'h100));
            dma_cnt = 0;
            wr(mct_pkg::ADDR_CTRL, 32'h1);
            repeat (40) @(posedge clk_in);
            rchk(mct_pkg::ADDR_COUNT, 32'(m));
            rchk(mct_pkg::ADDR_CTRL, 32'h0);
            chk({31'h0, mout[0]}, (a == 2) ? 32'h1 : 32'h0);
            chk(32'(dma_cnt), 32'h1);
        end
        $display("test stop and pins done");
        rst_pulse();
        wr({mct_pkg::PAGE_MATCH, 4'h4}, 32'h2);
        wr(mct_pkg::ADDR_MCTL, 32'h18);
        wr(mct_pkg::ADDR_MASK, 32'h2);
        wr(mct_pkg::ADDR_CTRL, 32'h1);
        for (k = 0; k < 50 && irq !== 1'b1; k++) @(posedge clk_in);
        wr(mct_pkg::ADDR_CTRL, 32'h0);
        rd(mct_pkg::ADDR_COUNT, d);
        chk({31'h0, d <= 32'h2}, 32'h1);
        rd(mct_pkg::ADDR_STAT, d);
        chk(d & 32'h2, 32'h2);
        chk({31'h0, irq}, 32'h1);
        wr(mct_pkg::ADDR_MASK, 32'h0);
        #1;
        chk({31'h0, irq}, 32'h0);
        wr(mct_pkg::ADDR_MASK, 32'h2);
        wr(mct_pkg::ADDR_STAT, 32'hff);
        rchk(mct_pkg::ADDR_STAT, 32'h0);
        chk({31'h0, irq}, 32'h0);
        $display("test interrupt done");
        rst_pulse();
        wr(mct_pkg::ADDR_CCTL, 32'h31);
        wr(mct_pkg::ADDR_CTRL, 32'h5);
        @(posedge clk_in);
        lvl <= 4'h2;
        repeat (6) @(posedge clk_in);
        lvl <= 4'h3;
        w = $urandom_range(40, 5);
        repeat (w) @(posedge clk_in);
        lvl <= 4'h1;
        repeat (6) @(posedge clk_in);
        wr(mct_pkg::ADDR_CTRL, 32'h0);
        rchk({mct_pkg::PAGE_CAPT, 4'h4}, 32'(w - 1));
        rd(mct_pkg::ADDR_STAT, d);
        chk(d & 32'hf0, 32'h20);
        wr({mct_pkg::PAGE_CAPT, 4'h4}, 32'h5);
        rchk({mct_pkg::PAGE_CAPT, 4'h4}, 32'(w - 1));
        // Pins return low before the next reset, so the cleared synchroniser sees no false edge.
        lvl <= 4'h0;
        $display("test capture done");
        rst_pulse();
        wr(mct_pkg::ADDR_CTRL, 32'h3);
        k = $urandom_range(8, 1);
        @(posedge clk_in);
        n <= 8'(k);
        go <= 1'b1;
        @(posedge clk_in);
        go <= 1'b0;
        repeat (6 * k + 12) @(posedge clk_in);
        wr(mct_pkg::ADDR_CTRL, 32'h0);
        rchk(mct_pkg::ADDR_COUNT, 32'(k));
        $display("test counter mode done");
        // PWM on pin 0 with a period of ten cycles set by match 3; match 1 requests DMA.
        rst_pulse();
        m = $urandom_range(8, 1);
        wr({mct_pkg::PAGE_MATCH, 4'hc}, 32'h9);
        wr({mct_pkg::PAGE_MATCH, 4'h0}, 32'(m));
        wr({mct_pkg::PAGE_MATCH, 4'h4}, 32'(m));
        wr(mct_pkg::ADDR_MCTL, 32'h401);
        wr(mct_pkg::ADDR_PWM, 32'h1);
        wr(mct_pkg::ADDR_DMA, 32'h2);
        wr(mct_pkg::ADDR_CTRL, 32'h1);
        repeat (20) @(posedge clk_in);
        #1;
        hi = 0;
        dma1_cnt = 0;
        repeat (40) begin
            @(posedge clk_in);
            #1;
            if (mout[0] === 1'b1) hi++;
        end
        wr(mct_pkg::ADDR_CTRL, 32'h0);
        chk(32'(hi), 32'(4 * (9 - m)));
        chk(32'(dma1_cnt), 32'h4);
        rd(mct_pkg::ADDR_STAT, d);
        chk(d & 32'h1, 32'h1);
        $display("test pwm done");
        complete_run();
    end
endmodule
`default_nettype wire
